// [design/coef_bit_defs.svh]
// Constants for the coefficient-pointer bit-addressing unit.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef COEF_BIT_DEFS_SVH
`define COEF_BIT_DEFS_SVH

// =====================================================================
// Widths
`define PTR_W 23
`define LOW_W 16
`define HIGH_W 7
`define ACC_W 40
`define ACC_HI_W 8
`define BITSEL_W 6
`define BYTE_W 8
`define ADDR_W 8
`define DATA_W 32

// =====================================================================
// Register offsets (byte addresses on the plain register port)
`define REG_PTR 8'h00
`define REG_BUF_START 8'h04
`define REG_CTRL 8'h08
`define REG_STATUS 8'h0c
`define REG_ACC2_LO 8'h10
`define REG_ACC2_HI 8'h14
`define REG_ACC3_LO 8'h18
`define REG_ACC3_HI 8'h1c

// =====================================================================
// Field positions and reset values
`define CTRL_CIRC 0
`define ST_TF1 0
`define ST_TF2 1
`define ST_BUSY 2
`define PTR_RESET 23'h000000
`define BUF_START_RESET 16'h0000
`define ACC_RESET 40'h0000000000

// =====================================================================
// Pointer steps for one-bit and two-bit operations
`define STEP_ONE 23'h000001
`define STEP_TWO 23'h000002

`endif

// [design/coef_bit_pkg.sv]
// Types shared by the coefficient-pointer bit-addressing unit.
// Assumes nothing of its surroundings.
package coef_bit_pkg;

    // =================================================================
    // Operand forms, operations and sequencer states.
    typedef enum logic [2:0] {
        MODE_PLAIN = 3'h0,
        MODE_POSTINC = 3'h1,
        MODE_POSTDEC = 3'h2,
        MODE_OFFSET = 3'h3,
        MODE_PREMOD = 3'h4
    } mode_t;

    typedef enum logic [1:0] {
        KIND_SET = 2'h0,
        KIND_CLEAR = 2'h1,
        KIND_PAIRTEST = 2'h2
    } kind_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_EXT_HI = 4'h2,
        S_EXT_LO = 4'h4,
        S_EXEC = 4'h8
    } state_t;

endpackage

// [design/coef_bit_if.sv]
// Interface joining the unit's sequencer to its address and bit paths.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/100ps
`include "coef_bit_defs.svh"

interface coef_bit_if;
    logic [`PTR_W-1:0] pointer;
    logic [`LOW_W-1:0] bufStart;
    logic circOn;
    coef_bit_pkg::mode_t mode;
    logic twoBit;
    logic [`LOW_W-1:0] offset;
    logic [`PTR_W-1:0] bitAddr;
    logic [`PTR_W-1:0] nextPtr;
    logic [`ACC_W-1:0] accIn;
    coef_bit_pkg::kind_t kind;
    logic [`ACC_W-1:0] accOut;
    logic flagOne;
    logic flagTwo;

    modport gen (input pointer, bufStart, circOn, mode, twoBit, offset,
        output bitAddr, nextPtr);
    modport alu (input accIn, kind, bitAddr, output accOut, flagOne, flagTwo);
endinterface

// [design/coef_addr_gen.sv]
// Bit-address generator for the coefficient-pointer operand forms.
// Purely combinational; assumes a caller that registers the results.
`timescale 1ns/100ps
`include "coef_bit_defs.svh"

module coef_addr_gen
(
    // Operands in, bit address and updated pointer out.
    coef_bit_if.gen port
);

    // =================================================================
    // Helpers
    function automatic logic [`PTR_W-1:0] sext16(input logic [`LOW_W-1:0] v);
        return {{`HIGH_W{v[`LOW_W-1]}}, v};
    endfunction

    function automatic logic [`PTR_W-1:0] stepOf(input logic two);
        return two ? `STEP_TWO : `STEP_ONE;
    endfunction

    // =================================================================
    // Address arithmetic
    logic [`PTR_W-1:0] extOffset;
    logic [`PTR_W-1:0] base;
    logic [`LOW_W-1:0] offsetTerm;
    logic [`LOW_W-1:0] lowPart;

    // Only the low part takes the signed-offset constant and buffer start, so a carry out
    // of the low part never disturbs the high part; pre-modify adds to the full pointer.
    always_comb
    begin
        extOffset = sext16(port.offset);
        base = port.pointer;
        if (port.mode == coef_bit_pkg::MODE_PREMOD)
        begin
            base = port.pointer + extOffset;
        end
        offsetTerm = '0;
        if (port.mode == coef_bit_pkg::MODE_OFFSET)
        begin
            offsetTerm = extOffset[`LOW_W-1:0];
        end
        lowPart = base[`LOW_W-1:0] + offsetTerm
            + (port.circOn ? port.bufStart : '0);
        port.bitAddr = {base[`PTR_W-1:`LOW_W], lowPart};
        case (port.mode)
            coef_bit_pkg::MODE_POSTINC: port.nextPtr = port.pointer + stepOf(port.twoBit);
            coef_bit_pkg::MODE_POSTDEC: port.nextPtr = port.pointer - stepOf(port.twoBit);
            coef_bit_pkg::MODE_PREMOD: port.nextPtr = base;
            default: port.nextPtr = port.pointer;
        endcase
    end

endmodule // coef_addr_gen

// [design/coef_bit_alu.sv]
// Bit set, clear and paired test on one accumulator.
// Assumes the caller writes back the accumulator and flags.
`timescale 1ns/100ps
`include "coef_bit_defs.svh"

module coef_bit_alu
(
    // Accumulator and bit address in, result and flags out.
    coef_bit_if.alu port
);

    // =================================================================
    // Helpers
    function automatic logic inRange(input logic [`BITSEL_W-1:0] idx);
        return idx < `BITSEL_W'(`ACC_W);
    endfunction

    // =================================================================
    // Bit operations
    logic [`BITSEL_W-1:0] idx;
    logic [`BITSEL_W-1:0] idxNext;
    logic okFirst;
    logic okSecond;

    // Bit numbers beyond the accumulator read as zero and are never written.
    always_comb
    begin
        idx = port.bitAddr[`BITSEL_W-1:0];
        idxNext = idx + `BITSEL_W'(1);
        okFirst = inRange(idx);
        okSecond = inRange(idxNext) && (idxNext != '0);
        port.accOut = port.accIn;
        port.flagOne = okFirst ? port.accIn[idx] : 1'b0;
        port.flagTwo = okSecond ? port.accIn[idxNext] : 1'b0;
        case (port.kind)
            coef_bit_pkg::KIND_SET:
            begin
                if (okFirst)
                begin
                    port.accOut[idx] = 1'b1;
                end
            end
            coef_bit_pkg::KIND_CLEAR:
            begin
                if (okFirst)
                begin
                    port.accOut[idx] = 1'b0;
                end
            end
            default: port.accOut = port.accIn;
        endcase
    end

endmodule // coef_bit_alu

// [design/coef_bit_unit.sv]
// Coefficient-pointer bit-addressing unit: sequencer, registers, checks.
// Assumes one clock, a plain register port and an instruction issue port.
//
// Behaviour
// - Pointer is 23 bits: 7-bit high part and 16-bit low offset part.
// - Post-increment: use pointer, then add 1, or 2 for a bit pair.
// - Post-decrement: use pointer, then subtract 1, or 2 for a bit pair.
// - Signed offset: sign-extend 16-bit constant, add to pointer low part.
// - Signed offset form leaves the stored pointer unchanged.
// - Pre-modify: add constant to full pointer, store it, then address.
// - The 16-bit constant arrives as a two-byte extension after the op.
// - Ops with the constant extension never issue in parallel.
// - Pair test copies addressed bit and the next one into the test flags.
// - Bit set forces the addressed accumulator bit to one.
// - Bit clear forces the addressed accumulator bit to zero.
// - Plain and signed-offset forms leave the full pointer unmodified.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "coef_bit_defs.svh"

module coef_bit_unit
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port.
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire logic [`DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [`DATA_W-1:0] regRdata,
    // Instruction issue.
    input wire logic opStart,
    input wire coef_bit_pkg::mode_t opMode,
    input wire coef_bit_pkg::kind_t opKind,
    input wire logic opAccSel,
    output logic busy,
    output logic opDone,
    output logic parallelOk,
    // Extension bytes of the offset constant.
    input wire logic extValid,
    input wire logic [`BYTE_W-1:0] extByte,
    // Status flags.
    output logic testFlagOne,
    output logic testFlagTwo
);

    // =================================================================
    // State
    coef_bit_pkg::state_t state, next_state;
    coef_bit_pkg::mode_t curMode, next_curMode;
    coef_bit_pkg::kind_t curKind, next_curKind;
    logic curAcc, next_curAcc;
    logic [`LOW_W-1:0] offsetConstant16, next_offsetConstant16;
    logic [`PTR_W-1:0] fullCoefPointer, next_fullCoefPointer;
    logic [`LOW_W-1:0] coefBufferStart, next_coefBufferStart;
    logic circularOn, next_circularOn;
    logic [`ACC_W-1:0] accumulatorTwo, next_accumulatorTwo;
    logic [`ACC_W-1:0] accumulatorThree, next_accumulatorThree;
    logic next_testFlagOne, next_testFlagTwo;
    logic next_opDone;
    logic [`DATA_W-1:0] next_regRdata;
    logic inExec;
    logic [`ACC_W-1:0] selAcc;
    logic [`HIGH_W-1:0] coefPointerHigh;
    logic [`LOW_W-1:0] coefPointerLow;

    coef_bit_if link();

    // =================================================================
    // Datapath
    coef_addr_gen addrGen
    (
        .port(link)
    );

    coef_bit_alu bitAlu
    (
        .port(link)
    );

    function automatic logic needsExt(input coef_bit_pkg::mode_t m);
        return (m == coef_bit_pkg::MODE_OFFSET) || (m == coef_bit_pkg::MODE_PREMOD);
    endfunction

    // Pointer split into its two parts; arithmetic runs on the full value.
    assign coefPointerHigh = fullCoefPointer[`PTR_W-1:`LOW_W];
    assign coefPointerLow = fullCoefPointer[`LOW_W-1:0];
    assign inExec = (state == coef_bit_pkg::S_EXEC);
    assign selAcc = curAcc ? accumulatorThree : accumulatorTwo;
    assign link.pointer = fullCoefPointer;
    assign link.bufStart = coefBufferStart;
    assign link.circOn = circularOn;
    assign link.mode = curMode;
    assign link.twoBit = (curKind == coef_bit_pkg::KIND_PAIRTEST);
    assign link.offset = offsetConstant16;
    assign link.accIn = selAcc;
    assign link.kind = curKind;

    // Handshake outputs straight from state and the issue request.
    assign busy = (state != coef_bit_pkg::S_IDLE);
    assign parallelOk = !needsExt(opMode);

    // =================================================================
    // Sequencer and register next values
    // Hardware updates win over a software write in the same cycle, so a
    // write to a register the executing op updates is lost rather than half-applied.
    always_comb
    begin
        next_state = state;
        next_curMode = curMode;
        next_curKind = curKind;
        next_curAcc = curAcc;
        next_offsetConstant16 = offsetConstant16;
        next_fullCoefPointer = fullCoefPointer;
        next_coefBufferStart = coefBufferStart;
        next_circularOn = circularOn;
        next_accumulatorTwo = accumulatorTwo;
        next_accumulatorThree = accumulatorThree;
        next_testFlagOne = testFlagOne;
        next_testFlagTwo = testFlagTwo;
        next_opDone = 1'b0;
        if (regWrite)
        begin
            case (regAddr)
                `REG_PTR: next_fullCoefPointer = regWdata[`PTR_W-1:0];
                `REG_BUF_START: next_coefBufferStart = regWdata[`LOW_W-1:0];
                `REG_CTRL: next_circularOn = regWdata[`CTRL_CIRC];
                `REG_STATUS:
                begin
                    next_testFlagOne = regWdata[`ST_TF1];
                    next_testFlagTwo = regWdata[`ST_TF2];
                end
                `REG_ACC2_LO: next_accumulatorTwo[`DATA_W-1:0] = regWdata;
                `REG_ACC2_HI: next_accumulatorTwo[`ACC_W-1:`DATA_W] = regWdata[`ACC_HI_W-1:0];
                `REG_ACC3_LO: next_accumulatorThree[`DATA_W-1:0] = regWdata;
                `REG_ACC3_HI: next_accumulatorThree[`ACC_W-1:`DATA_W] = regWdata[`ACC_HI_W-1:0];
                default: next_circularOn = circularOn;
            endcase
        end
        case (state)
            coef_bit_pkg::S_IDLE:
            begin
                if (opStart)
                begin
                    next_curMode = opMode;
                    next_curKind = opKind;
                    next_curAcc = opAccSel;
                    next_offsetConstant16 = '0;
                    next_state = needsExt(opMode) ? coef_bit_pkg::S_EXT_HI
                        : coef_bit_pkg::S_EXEC;
                end
            end
            coef_bit_pkg::S_EXT_HI:
            begin
                if (extValid)
                begin
                    next_offsetConstant16[`LOW_W-1:`BYTE_W] = extByte;
                    next_state = coef_bit_pkg::S_EXT_LO;
                end
            end
            coef_bit_pkg::S_EXT_LO:
            begin
                if (extValid)
                begin
                    next_offsetConstant16[`BYTE_W-1:0] = extByte;
                    next_state = coef_bit_pkg::S_EXEC;
                end
            end
            coef_bit_pkg::S_EXEC:
            begin
                next_fullCoefPointer = link.nextPtr;
                if (curKind == coef_bit_pkg::KIND_PAIRTEST)
                begin
                    next_testFlagOne = link.flagOne;
                    next_testFlagTwo = link.flagTwo;
                end
                else if (curAcc)
                begin
                    next_accumulatorThree = link.accOut;
                end
                else
                begin
                    next_accumulatorTwo = link.accOut;
                end
                next_opDone = 1'b1;
                next_state = coef_bit_pkg::S_IDLE;
            end
            default: next_state = coef_bit_pkg::S_IDLE;
        endcase
    end

    // Read data for the cycle after the read strobe; unmapped reads give zero.
    always_comb
    begin
        next_regRdata = '0;
        if (regRead)
        begin
            case (regAddr)
                `REG_PTR: next_regRdata = {{(`DATA_W-`PTR_W){1'b0}}, coefPointerHigh, coefPointerLow};
                `REG_BUF_START: next_regRdata = {{(`DATA_W-`LOW_W){1'b0}}, coefBufferStart};
                `REG_CTRL: next_regRdata[`CTRL_CIRC] = circularOn;
                `REG_STATUS:
                begin
                    next_regRdata[`ST_TF1] = testFlagOne;
                    next_regRdata[`ST_TF2] = testFlagTwo;
                    next_regRdata[`ST_BUSY] = busy;
                end
                `REG_ACC2_LO: next_regRdata = accumulatorTwo[`DATA_W-1:0];
                `REG_ACC2_HI: next_regRdata[`ACC_HI_W-1:0] = accumulatorTwo[`ACC_W-1:`DATA_W];
                `REG_ACC3_LO: next_regRdata = accumulatorThree[`DATA_W-1:0];
                `REG_ACC3_HI: next_regRdata[`ACC_HI_W-1:0] = accumulatorThree[`ACC_W-1:`DATA_W];
                default: next_regRdata = '0;
            endcase
        end
    end

    // Registers only; all decisions are made above.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= coef_bit_pkg::S_IDLE;
            curMode <= coef_bit_pkg::MODE_PLAIN;
            curKind <= coef_bit_pkg::KIND_SET;
            curAcc <= 1'b0;
            offsetConstant16 <= '0;
            fullCoefPointer <= `PTR_RESET;
            coefBufferStart <= `BUF_START_RESET;
            circularOn <= 1'b0;
            accumulatorTwo <= `ACC_RESET;
            accumulatorThree <= `ACC_RESET;
            testFlagOne <= 1'b0;
            testFlagTwo <= 1'b0;
            opDone <= 1'b0;
            regRdata <= '0;
        end
        else
        begin
            state <= next_state;
            curMode <= next_curMode;
            curKind <= next_curKind;
            curAcc <= next_curAcc;
            offsetConstant16 <= next_offsetConstant16;
            fullCoefPointer <= next_fullCoefPointer;
            coefBufferStart <= next_coefBufferStart;
            circularOn <= next_circularOn;
            accumulatorTwo <= next_accumulatorTwo;
            accumulatorThree <= next_accumulatorThree;
            testFlagOne <= next_testFlagOne;
            testFlagTwo <= next_testFlagTwo;
            opDone <= next_opDone;
            regRdata <= next_regRdata;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic [`BITSEL_W-1:0] bitIdx;
    logic pairStep;
    assign bitIdx = link.bitAddr[`BITSEL_W-1:0];
    assign pairStep = link.twoBit;

    ptr_postinc_a: assert property (
        inExec && curMode == coef_bit_pkg::MODE_POSTINC
        |=> fullCoefPointer == $past(fullCoefPointer)
            + ($past(pairStep) ? `STEP_TWO : `STEP_ONE))
        else $error("Post-increment step is wrong.");

    ptr_postdec_a: assert property (
        inExec && curMode == coef_bit_pkg::MODE_POSTDEC
        |=> fullCoefPointer == $past(fullCoefPointer)
            - ($past(pairStep) ? `STEP_TWO : `STEP_ONE))
        else $error("Post-decrement step is wrong.");

    ptr_kept_a: assert property (
        inExec && (curMode == coef_bit_pkg::MODE_PLAIN
            || curMode == coef_bit_pkg::MODE_OFFSET)
        |=> $stable(fullCoefPointer))
        else $error("Pointer changed on a base-only form.");

    premod_addr_a: assert property (
        inExec && curMode == coef_bit_pkg::MODE_PREMOD && !circularOn
        |-> link.bitAddr == fullCoefPointer + {{`HIGH_W{offsetConstant16[`LOW_W-1]}},
            offsetConstant16} ##1 fullCoefPointer == $past(link.bitAddr))
        else $error("Pre-modify address or write-back is wrong.");

    offset_addr_a: assert property (
        inExec && curMode == coef_bit_pkg::MODE_OFFSET && !circularOn
        |-> link.bitAddr == {coefPointerHigh, coefPointerLow + offsetConstant16})
        else $error("Signed-offset address is wrong.");

    linear_addr_a: assert property (
        inExec && !circularOn && curMode != coef_bit_pkg::MODE_OFFSET
        && curMode != coef_bit_pkg::MODE_PREMOD |-> link.bitAddr == fullCoefPointer)
        else $error("Linear address differs from pointer.");

    // The fetch is checked one byte at a time, so any number of idle
    // cycles between the bytes is allowed without an open-ended sequence.
    ext_fetch_a: assert property (
        state == coef_bit_pkg::S_IDLE && opStart && needsExt(opMode)
        |=> state == coef_bit_pkg::S_EXT_HI)
        else $error("Extension fetch did not start.");

    ext_high_a: assert property (
        state == coef_bit_pkg::S_EXT_HI && extValid
        |=> state == coef_bit_pkg::S_EXT_LO
            && offsetConstant16[`LOW_W-1:`BYTE_W] == $past(extByte))
        else $error("High extension byte not taken.");

    ext_low_a: assert property (
        state == coef_bit_pkg::S_EXT_LO && extValid
        |=> inExec && offsetConstant16[`BYTE_W-1:0] == $past(extByte))
        else $error("Low extension byte not taken.");

    no_parallel_a: assert property (
        (opMode == coef_bit_pkg::MODE_OFFSET || opMode == coef_bit_pkg::MODE_PREMOD)
        |-> !parallelOk)
        else $error("Extension op allowed in parallel.");

    pair_test_a: assert property (
        inExec && curKind == coef_bit_pkg::KIND_PAIRTEST && bitIdx < `BITSEL_W'(`ACC_W - 1)
        |=> testFlagOne == $past(selAcc[bitIdx]) && testFlagTwo == $past(selAcc[bitIdx + 1'b1]))
        else $error("Test flags do not match accumulator bits.");

    bit_set_a: assert property (
        inExec && curKind == coef_bit_pkg::KIND_SET && bitIdx < `BITSEL_W'(`ACC_W) && !regWrite
        |=> selAcc[$past(bitIdx)] == 1'b1 && opDone)
        else $error("Bit set did not take.");

    bit_clear_a: assert property (
        inExec && curKind == coef_bit_pkg::KIND_CLEAR && bitIdx < `BITSEL_W'(`ACC_W) && !regWrite
        |=> selAcc[$past(bitIdx)] == 1'b0 && opDone)
        else $error("Bit clear did not take.");

    premod_seen_c: cover property (inExec && curMode == coef_bit_pkg::MODE_PREMOD);
    pair_test_c: cover property (inExec && curKind == coef_bit_pkg::KIND_PAIRTEST && pairStep);
    circular_c: cover property (inExec && circularOn);
    back_to_back_c: cover property (opDone && opStart);

endmodule // coef_bit_unit

// [testbench/coef_bit_unit_tb_top.sv]
// Self-checking bench for the coefficient-pointer bit-addressing unit.
// Assumes the package, constants header and design modules compile first.
`timescale 1ns/100ps
`include "coef_bit_defs.svh"

module coef_bit_unit_tb_top;
    // ==============================================================
    // Design ports and the bench's own model.
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic opStart = 1'b0;
    coef_bit_pkg::mode_t opMode = coef_bit_pkg::MODE_PLAIN;
    coef_bit_pkg::kind_t opKind = coef_bit_pkg::KIND_SET;
    logic opAccSel = 1'b0;
    logic extValid = 1'b0;
    logic [7:0] extByte = 8'h00;
    logic [31:0] regRdata;
    logic busy, opDone, parallelOk, testFlagOne, testFlagTwo;
    logic [39:0] acc [0:1] = '{40'h0000000000, 40'h0000000000};
    logic [15:0] bufS = 16'h0000;
    logic circ = 1'b0;
    logic flag1 = 1'b0;
    logic flag2 = 1'b0;
    logic readPend = 1'b0;
    logic [31:0] expQ [$];
    string nameQ [$];
    int badCount = 0;
    int totalChecks = 0;
    int cycles = 0;

    coef_bit_unit u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .opStart(opStart), .opMode(opMode), .opKind(opKind), .opAccSel(opAccSel),
        .busy(busy), .opDone(opDone), .parallelOk(parallelOk), .extValid(extValid),
        .extByte(extByte), .testFlagOne(testFlagOne), .testFlagTwo(testFlagTwo));

    // Free-running core clock, 8 ns period.
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmpWord(input string what, input logic [31:0] e, input logic [31:0] seen);
        totalChecks++;
        if (seen !== e)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, e, seen);
        end
    endtask

    task automatic cmpLevel(input string what, input logic [7:0] e, input logic [7:0] seen);
        cmpWord(what, {24'h000000, e}, {24'h000000, seen});
    endtask

    // Read data stands only in the cycle after the strobe, so the oldest note
    // is compared at the edge that closes that cycle. Also cuts a hang short.
    always @(posedge clk_sys)
    begin
        if (readPend)
            cmpWord(nameQ.pop_front(), expQ.pop_front(), regRdata);
        readPend <= regRead;
        cycles++;
        if (cycles == 6000)
        begin
            badCount++;
            final_report();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        expQ.push_back(e);
        nameQ.push_back(what);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
    endtask

    task automatic accRw(input int s, input logic wrOn, input logic [39:0] v);
        if (wrOn)
            acc[s] = v;
        if (wrOn)
            wr((s == 1) ? `REG_ACC3_LO : `REG_ACC2_LO, v[31:0]);
        if (wrOn)
            wr((s == 1) ? `REG_ACC3_HI : `REG_ACC2_HI, {24'h000000, v[39:32]});
        else
            rd((s == 1) ? `REG_ACC3_LO : `REG_ACC2_LO, acc[s][31:0], "accLo");
        if (!wrOn)
            rd((s == 1) ? `REG_ACC3_HI : `REG_ACC2_HI, {24'h000000, acc[s][39:32]}, "accHi");
    endtask

    // Modes 0..4 follow the operand forms, kinds 0 set, 1 clear, 2 pair test.
    task automatic runOp(input int m, input int k, input int s, input int p0, input int kc);
        logic [22:0] p;
        logic [22:0] np;
        logic [15:0] lo;
        logic [63:0] r;
        int n;
        int lat;
        p = p0[22:0];
        r = {$urandom(), $urandom()};
        np = p + {{7{kc[15]}}, kc[15:0]};
        lo = ((m == 4) ? np[15:0] : p[15:0]) + ((m == 3) ? kc[15:0] : 16'h0000);
        lo = lo + (circ ? bufS : 16'h0000);
        n = lo[5:0];
        if (m == 1 || m == 2)
            np = (m == 1) ? p + ((k == 2) ? 23'h2 : 23'h1) : p - ((k == 2) ? 23'h2 : 23'h1);
        else if (m != 4)
            np = p;
        wr(`REG_PTR, {9'h000, p});
        accRw(s, 1'b1, r[39:0]);
        @(posedge clk_sys);
        opMode <= coef_bit_pkg::mode_t'(m[2:0]);
        opKind <= coef_bit_pkg::kind_t'(k[1:0]);
        opAccSel <= s[0];
        opStart <= 1'b1;
        @(posedge clk_sys);
        opStart <= 1'b0;
        lat = 0;
        cmpLevel("parallelOk", {7'h00, m < 3}, {7'h00, parallelOk});
        if (m >= 3)
        begin
            extValid <= 1'b1;
            extByte <= kc[15:8];
            @(posedge clk_sys);
            extByte <= kc[7:0];
            @(posedge clk_sys);
            extValid <= 1'b0;
            lat = 2;
        end
        while (opDone !== 1'b1 && lat < 12)
        begin
            @(negedge clk_sys);
            lat++;
            cmpLevel("busy", {7'h00, lat < ((m >= 3) ? 4 : 2)}, {7'h00, busy});
        end
        cmpLevel("latency", (m >= 3) ? 8'h04 : 8'h02, lat[7:0]);
        if (k < 2 && n < 40)
            acc[s][n] = (k == 0);
        if (k == 2)
        begin
            flag1 = (n < 40) ? acc[s][n] : 1'b0;
            flag2 = (n < 39) ? acc[s][n + 1] : 1'b0;
        end
        rd(`REG_PTR, {9'h000, np}, "pointer");
        accRw(s, 1'b0, 40'h0000000000);
        rd(`REG_STATUS, {29'h0, 1'b0, flag2, flag1}, "status");
        cmpLevel("flags", {6'h00, flag2, flag1}, {6'h00, testFlagTwo, testFlagOne});
    endtask

    // Main sequence: register port, fixed cases, random cases, circular mode.
    initial
    begin
        void'($urandom(32'h63091976));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(`REG_PTR, 32'h0, "ptrReset");
        rd(8'h20, 32'h0, "unmapped");
        wr(`REG_STATUS, 32'h00000007);
        rd(`REG_STATUS, 32'h00000003, "statusWr");
        wr(`REG_STATUS, 32'h0);
        wr(`REG_PTR, 32'hffffffff);
        rd(`REG_PTR, 32'h007fffff, "ptrWidth");
        $display("test registers done");
        runOp(0, 0, 1, 0, 0);
        runOp(1, 2, 1, 30, 0);
        runOp(2, 0, 1, 0, 0);
        runOp(2, 2, 1, 30, 0);
        runOp(3, 1, 0, 40, 'hfff7);
        runOp(3, 2, 0, 16, 5);
        runOp(4, 1, 0, 0, 31);
        runOp(4, 2, 0, 16, 5);
        runOp(1, 1, 0, 'h7fffff, 0);
        runOp(0, 2, 0, 39, 0);
        $display("test fixed cases done");
        repeat (12)
            runOp($urandom_range(4, 0), $urandom_range(2, 0), $urandom_range(1, 0),
                $urandom_range(60, 0), $urandom_range(20, 0));
        $display("test random cases done");
        circ = 1'b1;
        bufS = 16'h000a;
        wr(`REG_BUF_START, 32'h0000000a);
        wr(`REG_CTRL, 32'h00000001);
        runOp(0, 0, 0, 3, 0);
        runOp(4, 1, 1, 2, 4);
        $display("test circular done");
        // Let the last read's data cycle pass so its note is compared.
        repeat (2) @(posedge clk_sys);
        final_report();
    end
endmodule // coef_bit_unit_tb_top
